// [rtl/usfl_pkg.sv]
package usfl_pkg;
   // ******************************************************
   // Register offsets on the plain register port.
   // ******************************************************
   localparam logic [3:0] REG_TXBUF   = 4'h0;
   localparam logic [3:0] REG_RXBUF   = 4'h1;
   localparam logic [3:0] REG_STATUS  = 4'h2;
   localparam logic [3:0] REG_CTRL    = 4'h3;
   localparam logic [3:0] REG_ISTAT   = 4'h4;
   localparam logic [3:0] REG_IMASK   = 4'h5;
   // ******************************************************
   // Field positions of the status register.
   // ******************************************************
   localparam int ST_RX_BUFFER_FULL_FLAG = 0;
   localparam int ST_FERR = 1;
   localparam int ST_PARITY_ERROR_FLAG = 2;
   localparam int ST_OVERRUN_ERROR_FLAG = 3;
   localparam int ST_TX_BUFFER_FULL_FLAG = 4;
   localparam int ST_TBSY = 5;
   // ******************************************************
   // Field positions of the interrupt status and mask.
   // ******************************************************
   localparam int IS_TX = 0;
   localparam int IS_RX = 1;
   // ******************************************************
   // Field positions of the control register.
   // ******************************************************
   localparam int CT_IRDA = 0;
   // ******************************************************
   // Reset values and the infrared pulse fraction.
   // ******************************************************
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [1:0] IMASK_RST = 2'h0;
   localparam logic [4:0] IR_PULSE_16THS = 5'h03;
   localparam logic [4:0] BIT_16THS      = 5'h10;
endpackage

// [rtl/usfl_top.sv]
`timescale 1ns/1ps
// Functional notes
// RULE1 - Empty or loaded shifter clears tx-full flag; here only a shifter load (tx_load_i) clears it
// RULE2 - Tx-full clear raises transmit interrupt
// RULE3 - Host byte write sets tx-full flag
// RULE4 - No flags means nothing received yet
// RULE5 - Overrun only means bytes were lost
// RULE6 - Full without errors means good byte
// RULE7 - Full with overrun means later losses
// RULE8 - Full with frame/parity means corrupt byte
// RULE9 - Host judges interrupt by error flags
// RULE10 - Host discards corrupted byte, receives again
// RULE11 - Host restarts transfer after overrun
// RULE12 - Lower baud or use flow control
// RULE13 - Host reenables nesting after both reads
// RULE14 - Infrared low bit pulses 3/16 bit
// RULE15 - Overrun sets flag, drops new byte
// RULE16 - Loading receive buffer sets rx-full
// RULE17 - Flags seen in status clear on buffer read
// RULE18 - Zero stop bit sets framing, interrupts
// RULE19 - Interrupt requests are one-cycle pulses
module usfl_top
   import usfl_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       rx_done_i,
   input  wire logic [7:0] rx_byte_i,
   input  wire logic       rx_stop_i,
   input  wire logic       rx_par_err_i,
   input  wire logic       tx_load_i,
   input  wire logic       tx_idle_i,
   input  wire logic       tx_bit_i,
   input  wire logic       bit_tick_i,
   output logic      [7:0] tx_byte_o,
   output logic            tx_avail_o,
   output logic            txd_o,
   output logic            tx_irq_o,
   output logic            rx_irq_o,
   output logic            irq_o
);

   // ******************************************************
   // Reset release and state.
   // ******************************************************
   logic [1:0] rst_sync_ff;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   typedef struct packed {
      logic [7:0] tx_holding_buffer;
      logic [7:0] rx_data_buffer;
      logic       tx_buffer_full_flag;
      logic       tx_busy;
      logic       rx_buffer_full_flag;
      logic       framing_error_flag;
      logic       parity_error_flag;
      logic       overrun_error_flag;
      logic [3:0] seen;
      logic [7:0] ctrl;
      logic [1:0] istat;
      logic [1:0] imask;
      logic       tx_irq;
      logic       rx_irq;
      logic [7:0] rdata;
      logic [4:0] sub;
      logic       txd;
   } usfl_state_t;

   usfl_state_t st_ff;
   usfl_state_t nxt_st;

   logic [7:0] status;
   logic       txb_wr;
   logic       st_rd;
   logic       rxb_rd;
   logic       tx_buffer_full_flag_clr;
   logic       rx_load;
   logic       rx_ovr;

   always_comb begin
      status          = 8'h00;
      // RULE6 full means good
      status[ST_RX_BUFFER_FULL_FLAG] = st_ff.rx_buffer_full_flag;
      // RULE8 corrupt byte flags
      status[ST_FERR] = st_ff.framing_error_flag;
      status[ST_PARITY_ERROR_FLAG] = st_ff.parity_error_flag;
      // RULE5 RULE7 losses flagged
      status[ST_OVERRUN_ERROR_FLAG] = st_ff.overrun_error_flag;
      status[ST_TX_BUFFER_FULL_FLAG] = st_ff.tx_buffer_full_flag;
      status[ST_TBSY] = st_ff.tx_busy;
   end

   assign txb_wr   = wr_i && (addr_i == REG_TXBUF);
   assign st_rd    = rd_i && (addr_i == REG_STATUS);
   assign rxb_rd   = rd_i && (addr_i == REG_RXBUF);
   assign tx_buffer_full_flag_clr = st_ff.tx_buffer_full_flag && tx_load_i;
   assign rx_load  = rx_done_i && !st_ff.rx_buffer_full_flag;
   assign rx_ovr   = rx_done_i && st_ff.rx_buffer_full_flag;

   // ******************************************************
   // Next-state logic.
   // ******************************************************
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.tx_irq = 1'b0;
      nxt_st.rx_irq = 1'b0;
      nxt_st.rdata  = 8'h00;

      // Status read snapshots the receive flags; a buffer read clears only those.
      // RULE17 flags cleared
      if (rxb_rd) begin
         if (st_ff.seen[0]) nxt_st.rx_buffer_full_flag = 1'b0;
         if (st_ff.seen[1]) nxt_st.framing_error_flag  = 1'b0;
         if (st_ff.seen[2]) nxt_st.parity_error_flag   = 1'b0;
         if (st_ff.seen[3]) nxt_st.overrun_error_flag  = 1'b0;
         nxt_st.seen = 4'h0;
      end
      if (st_rd) begin
         nxt_st.seen = status[3:0];
      end

      // RULE16 buffer load
      if (rx_load) begin
         nxt_st.rx_data_buffer      = rx_byte_i;
         nxt_st.rx_buffer_full_flag = 1'b1;
         nxt_st.parity_error_flag   = rx_par_err_i;
         // RULE18 framing error
         nxt_st.framing_error_flag  = !rx_stop_i;
         nxt_st.rx_irq              = 1'b1;
      end
      // RULE15 overrun drop
      if (rx_ovr) begin
         nxt_st.overrun_error_flag = 1'b1;
         nxt_st.rx_irq             = !st_ff.overrun_error_flag;
      end

      // RULE1 cleared on load
      if (tx_buffer_full_flag_clr) begin
         nxt_st.tx_buffer_full_flag = 1'b0;
         nxt_st.tx_busy             = 1'b1;
         // RULE2 transmit request
         nxt_st.tx_irq              = 1'b1;
      end else if (tx_idle_i && !st_ff.tx_buffer_full_flag) begin
         nxt_st.tx_busy = 1'b0;
      end
      // A write in the load cycle refills the buffer, so the set wins.
      // RULE3 set on write
      if (txb_wr) begin
         nxt_st.tx_holding_buffer   = wdata_i;
         nxt_st.tx_buffer_full_flag = 1'b1;
      end

      // Sticky interrupt status: set wins over write-one-to-clear.
      if (wr_i && addr_i == REG_ISTAT) nxt_st.istat = st_ff.istat & ~wdata_i[1:0];
      if (st_ff.tx_irq) nxt_st.istat[IS_TX] = 1'b1;
      if (st_ff.rx_irq) nxt_st.istat[IS_RX] = 1'b1;
      if (wr_i && addr_i == REG_IMASK) nxt_st.imask = wdata_i[1:0];
      if (wr_i && addr_i == REG_CTRL)  nxt_st.ctrl  = wdata_i;

      if (rd_i) begin
         case (addr_i)
            REG_TXBUF:  nxt_st.rdata = st_ff.tx_holding_buffer;
            REG_RXBUF:  nxt_st.rdata = st_ff.rx_data_buffer;
            // RULE4 status encoding
            REG_STATUS: nxt_st.rdata = status;
            REG_CTRL:   nxt_st.rdata = st_ff.ctrl;
            REG_ISTAT:  nxt_st.rdata = {6'h00, st_ff.istat};
            REG_IMASK:  nxt_st.rdata = {6'h00, st_ff.imask};
            default:    nxt_st.rdata = 8'h00;
         endcase
      end

      // Infrared: a low bit is a short low pulse, otherwise the line idles high.
      if (bit_tick_i) nxt_st.sub = 5'h00;
      else if (st_ff.sub != BIT_16THS) nxt_st.sub = st_ff.sub + 5'h01;
      // RULE14 infrared pulse
      if (st_ff.ctrl[CT_IRDA]) nxt_st.txd = tx_bit_i || (nxt_st.sub >= IR_PULSE_16THS);
      else nxt_st.txd = tx_bit_i;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff       <= '0;
         st_ff.ctrl  <= CTRL_RST;
         st_ff.imask <= IMASK_RST;
         st_ff.txd   <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ******************************************************
   // Outputs.
   // ******************************************************
   assign rdata_o    = st_ff.rdata;
   assign tx_byte_o  = st_ff.tx_holding_buffer;
   assign tx_avail_o = st_ff.tx_buffer_full_flag;
   assign txd_o      = st_ff.txd;
   // RULE19 single pulses
   assign tx_irq_o   = st_ff.tx_irq;
   assign rx_irq_o   = st_ff.rx_irq;
   assign irq_o      = |(st_ff.istat & st_ff.imask);

   // ******************************************************
   // Checks.
   // ******************************************************
   sequence s_tx_load;
      tx_buffer_full_flag_clr;
   endsequence

   AST_TX_BUFFER_FULL_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE1
      s_tx_load ##0 !txb_wr |=> !st_ff.tx_buffer_full_flag)
      else $error("tx full flag not cleared");
   AST_TXIRQ: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE2
      s_tx_load |=> tx_irq_o)
      else $error("no tx interrupt");
   AST_TX_BUFFER_FULL_FLAG_SET: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE3
      txb_wr && !tx_load_i |=> st_ff.tx_buffer_full_flag)
      else $error("tx full flag not set");
   AST_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE19
      tx_irq_o |=> !tx_irq_o)
      else $error("tx irq not a pulse");
   AST_RX_BUFFER_FULL_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE16
      rx_load |=> st_ff.rx_buffer_full_flag && rx_irq_o)
      else $error("rx full not set");
   AST_OVR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE15
      rx_ovr && !rxb_rd |=> st_ff.overrun_error_flag && $stable(st_ff.rx_data_buffer))
      else $error("overrun handling wrong");
   AST_FERR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE18
      rx_load && !rx_stop_i |=> st_ff.framing_error_flag)
      else $error("framing flag not set");
   AST_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE17
      rxb_rd && !st_ff.seen[0] && st_ff.rx_buffer_full_flag |=> st_ff.rx_buffer_full_flag)
      else $error("unseen rx full cleared");
   AST_IR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE14
      st_ff.ctrl[CT_IRDA] && st_ff.sub > IR_PULSE_16THS |-> txd_o)
      else $error("ir pulse too long");

   // ******************************************************
   // Receive checks and the transmit interrupt source check.
   // ******************************************************
   sequence s_rx_load;
      rx_load;
   endsequence

   sequence s_ovr_first;
      rx_ovr && !st_ff.overrun_error_flag;
   endsequence

   sequence s_ovr_again;
      rx_ovr && st_ff.overrun_error_flag;
   endsequence

   sequence s_status_rd;
      st_rd;
   endsequence

   AST_RXIRQ_OVR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE15
      s_ovr_first |=> rx_irq_o)
      else $error("no rx interrupt on first overrun");

   AST_RXIRQ_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE15
      s_ovr_again |=> !rx_irq_o)
      else $error("rx interrupt on repeated overrun");

   AST_OVR_FULL: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE15
      rx_ovr && !rxb_rd |=> st_ff.rx_buffer_full_flag)
      else $error("earlier byte lost on overrun");

   AST_RXIRQ_SRC: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE19
      rx_irq_o |-> $past(rx_done_i))
      else $error("rx interrupt without frame");

   AST_TXIRQ_SRC: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE19
      tx_irq_o |-> $past(tx_buffer_full_flag_clr))
      else $error("tx interrupt without load");

   AST_PARITY_ERROR_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE8
      s_rx_load |=> st_ff.parity_error_flag == $past(rx_par_err_i))
      else $error("parity flag wrong");

   AST_FERR_OK: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE6
      s_rx_load ##0 rx_stop_i |=> !st_ff.framing_error_flag)
      else $error("framing flag on good stop bit");

   AST_RXDATA: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE16
      s_rx_load |=> st_ff.rx_data_buffer == $past(rx_byte_i))
      else $error("rx buffer not loaded");

   AST_RX_BUFFER_FULL_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE17
      rxb_rd && st_ff.seen[0] && !rx_done_i |=> !st_ff.rx_buffer_full_flag)
      else $error("seen rx full not cleared");

   AST_OVR_CLR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE17
      rxb_rd && st_ff.seen[3] && !rx_done_i |=> !st_ff.overrun_error_flag)
      else $error("seen overrun not cleared");

   AST_OVR_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE5
      st_ff.overrun_error_flag && !(rxb_rd && st_ff.seen[3]) |=> st_ff.overrun_error_flag)
      else $error("overrun flag lost");

   AST_ST_RXFULL: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE6
      s_status_rd |=> rdata_o[ST_RX_BUFFER_FULL_FLAG] == $past(st_ff.rx_buffer_full_flag))
      else $error("status rx full wrong");

   AST_ST_OVR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE7
      s_status_rd |=> rdata_o[ST_OVERRUN_ERROR_FLAG] == $past(st_ff.overrun_error_flag))
      else $error("status overrun wrong");

   AST_ST_ERR: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE8
      s_status_rd |=> (rdata_o[ST_FERR] || rdata_o[ST_PARITY_ERROR_FLAG]) ==
         $past(st_ff.framing_error_flag || st_ff.parity_error_flag))
      else $error("status error flags wrong");

   AST_ST_EMPTY: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE4
      s_status_rd ##0 !st_ff.rx_buffer_full_flag ##0 !st_ff.overrun_error_flag
         |=> !rdata_o[ST_RX_BUFFER_FULL_FLAG] && !rdata_o[ST_OVERRUN_ERROR_FLAG])
      else $error("empty status wrong");

   AST_ISTAT_RX: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE18
      st_ff.rx_irq |=> st_ff.istat[IS_RX])
      else $error("rx interrupt not latched");

   // ******************************************************
   // Transmit checks.
   // ******************************************************
   AST_ISTAT_TX: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE2
      st_ff.tx_irq |=> st_ff.istat[IS_TX])
      else $error("tx interrupt not latched");

   AST_TBUF_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE3
      txb_wr |=> tx_byte_o == $past(wdata_i))
      else $error("holding buffer not written");

   AST_TBUF_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE3
      !txb_wr |=> $stable(tx_byte_o))
      else $error("holding buffer changed");

   AST_IR_LOW: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE14
      st_ff.ctrl[CT_IRDA] && bit_tick_i && !tx_bit_i |=> !txd_o)
      else $error("ir pulse missing");
endmodule

// [dv/usfl_remote.sv]
`timescale 1ns/1ps
// ************************
// Line-side frame source.
// ************************
module usfl_remote (
   input  wire logic       clk_i,
   output logic            rx_done_o,
   output logic      [7:0] rx_byte_o,
   output logic            rx_stop_o,
   output logic            rx_parity_error_flag_o,
   output logic            tx_load_o,
   output logic            tx_idle_o,
   output logic            tx_bit_o,
   output logic            tick_o
);
   initial begin
      rx_done_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_stop_o = 1'b1;
      rx_parity_error_flag_o = 1'b0;
      tx_load_o = 1'b0;
      tx_idle_o = 1'b1;
      tx_bit_o  = 1'b1;
      tick_o    = 1'b0;
   end
   task automatic frame(input logic [7:0] b, input logic stp, input logic par);
      @(posedge clk_i);
      rx_done_o <= 1'b1;
      rx_byte_o <= b;
      rx_stop_o <= stp;
      rx_parity_error_flag_o <= par;
      @(posedge clk_i);
      rx_done_o <= 1'b0;
      rx_byte_o <= ~b;
      rx_stop_o <= ~stp;
      rx_parity_error_flag_o <= ~par;
   endtask
   task automatic load();
      @(posedge clk_i);
      tx_load_o <= 1'b1;
      tx_idle_o <= 1'b0;
      @(posedge clk_i);
      tx_load_o <= 1'b0;
   endtask
   task automatic ir_bit(input logic b);
      @(posedge clk_i);
      tx_bit_o <= b;
      tick_o   <= 1'b1;
      @(posedge clk_i);
      tick_o   <= 1'b0;
      repeat (15) @(posedge clk_i);
      tx_bit_o <= 1'b1;
   endtask
endmodule

// [dv/uart_status_flag_logic_test.sv]
`timescale 1ns/1ps
module uart_status_flag_logic_test;
   import usfl_pkg::*;
   logic       clk_i, nrst_i, wr_i, rd_i, tx_avail_o, txd_o, tx_irq_o, rx_irq_o, irq_o;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rx_byte, tx_byte_o, d;
   logic       rx_done, rx_stop, rx_parity_error_flag, tx_load, tx_idle, tx_bit, tick;
   int         n_fail, checked, n_txirq, n_rxirq, n_low, l0;
   usfl_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_done_i(rx_done),
      .rx_byte_i(rx_byte), .rx_stop_i(rx_stop), .rx_par_err_i(rx_parity_error_flag),
      .tx_load_i(tx_load), .tx_idle_i(tx_idle), .tx_bit_i(tx_bit), .bit_tick_i(tick),
      .tx_byte_o(tx_byte_o), .tx_avail_o(tx_avail_o), .txd_o(txd_o),
      .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .irq_o(irq_o));
   usfl_remote rem (.clk_i(clk_i), .rx_done_o(rx_done), .rx_byte_o(rx_byte),
      .rx_stop_o(rx_stop), .rx_parity_error_flag_o(rx_parity_error_flag), .tx_load_o(tx_load),
      .tx_idle_o(tx_idle), .tx_bit_o(tx_bit), .tick_o(tick));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (tx_irq_o === 1'b1) n_txirq++;
      if (rx_irq_o === 1'b1) n_rxirq++;
      if (txd_o === 1'b0) n_low++;
   end
   // **************************
   // Register port tasks, the check task and the end-of-test task.
   // **************************
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      wdata_i <= ~v;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      conclude();
   end
   initial begin
      {nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
      {n_fail, checked, n_txirq, n_rxirq, n_low} = '0;
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(REG_STATUS);
      chk("status", d, 8'h00);
      rd(4'hf);
      chk("unmapped", d, 8'h00);
      wr(REG_TXBUF, 8'ha5);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h10);
      chk("tx_byte", tx_byte_o, 8'ha5);
      chk("tx_avail", {7'h0, tx_avail_o}, 8'h01);
      rem.load();
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h00);
      chk("tx_avail", {7'h0, tx_avail_o}, 8'h00);
      chk("tx_irq", n_txirq[7:0], 8'h01);
      rd(REG_ISTAT);
      chk("istat", d, 8'h01);
      wr(REG_IMASK, 8'h01);
      rd(REG_ISTAT);
      chk("irq", {7'h0, irq_o}, 8'h01);
      wr(REG_ISTAT, 8'h01);
      rd(REG_ISTAT);
      chk("istat", d, 8'h00);
      chk("irq", {7'h0, irq_o}, 8'h00);
      rem.frame(8'h5a, 1'b1, 1'b0);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h01);
      chk("irq", {7'h0, irq_o}, 8'h00);
      rd(REG_RXBUF);
      chk("rxbuf", d, 8'h5a);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h00);
      rem.frame(8'hc3, 1'b0, 1'b1);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h07);
      rd(REG_RXBUF);
      rem.frame(8'h11, 1'b1, 1'b0);
      rem.frame(8'h22, 1'b1, 1'b0);
      rem.frame(8'h23, 1'b1, 1'b0);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h09);
      rd(REG_RXBUF);
      chk("rxbuf", d, 8'h11);
      chk("rx_irq", n_rxirq[7:0], 8'h04);
      rem.frame(8'h33, 1'b1, 1'b0);
      rd(REG_STATUS);
      rem.frame(8'h44, 1'b1, 1'b0);
      rd(REG_RXBUF);
      chk("rxbuf", d, 8'h33);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h08);
      rd(REG_RXBUF);
      rd(REG_STATUS);
      chk("status", d & 8'h1f, 8'h00);
      wr(REG_CTRL, 8'h01);
      l0 = n_low;
      rem.ir_bit(1'b0);
      rem.ir_bit(1'b1);
      chk("ir_low", 8'(n_low - l0), 8'h03);
      conclude();
   end
endmodule
